// File: rtl/i2csb_pkg.sv
//
// Contract
// - Enable takes over data and clock pins
// - Works at bus clocks up to 400 kHz
// - Hardware compares 7-bit address, answers on match
// - Ten-bit and SMBus need firmware help only
// - Hardware detects conditions, generates acknowledge bits
// - Slave receives and transmits, byte at a time
// - Legacy mode stalls bus until firmware services
// - Buffered mode presents 32-byte RAM to master
// - Master sets buffer pointer; slave follows it
// - Buffered mode never stretches; returns current RAM
// - Low-power monitor watches bus activity
// - Registers expose data, status, flags and interrupts
package i2csb_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] I2CSB_OFS_CTRL   = 8'h00;
  localparam logic [7:0] I2CSB_OFS_ADDR   = 8'h04;
  localparam logic [7:0] I2CSB_OFS_STATUS = 8'h08;
  localparam logic [7:0] I2CSB_OFS_MASK   = 8'h0C;
  localparam logic [7:0] I2CSB_OFS_RXDATA = 8'h10;
  localparam logic [7:0] I2CSB_OFS_TXDATA = 8'h14;
  localparam logic [7:0] I2CSB_OFS_STATE  = 8'h18;
  localparam logic [7:0] I2CSB_OFS_BUF    = 8'h80;

  // ---------------------------------------------------------------
  // Control fields
  // ---------------------------------------------------------------
  localparam int I2CSB_CTL_EN   = 0;
  localparam int I2CSB_CTL_BUF  = 1;
  localparam int I2CSB_CTL_MON  = 2;
  localparam int I2CSB_CTL_NACK = 3;
  localparam int I2CSB_CTL_RLS  = 4;

  // ---------------------------------------------------------------
  // Status / mask bits
  // ---------------------------------------------------------------
  localparam int I2CSB_ST_ADDR  = 0;
  localparam int I2CSB_ST_RX    = 1;
  localparam int I2CSB_ST_TX    = 2;
  localparam int I2CSB_ST_STOP  = 3;
  localparam int I2CSB_ST_START = 4;
  localparam int I2CSB_ST_NAKD  = 5;
  localparam int I2CSB_ST_ACT   = 6;
  localparam int I2CSB_NEV      = 7;

  // ---------------------------------------------------------------
  // Reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [4:0] I2CSB_CTRL_RST = 5'h00;
  localparam logic [6:0] I2CSB_ADDR_RST = 7'h08;
  localparam int         I2CSB_BUF_DEPTH = 32;
  localparam int         I2CSB_PTR_W     = 5;

  // AXI responses
  localparam logic [1:0] I2CSB_RESP_OK  = 2'h0;
  localparam logic [1:0] I2CSB_RESP_ERR = 2'h2;

  // ---------------------------------------------------------------
  // Timing: fastest bus clock, and system clock
  // ---------------------------------------------------------------
  localparam int I2CSB_SCL_MAX_KHZ = 400;
  localparam int I2CSB_CLK_MHZ     = 100;
  // Least clocks per bus bit at the top rate
  localparam int I2CSB_CYC_PER_BIT =
    (I2CSB_CLK_MHZ * 1000) / I2CSB_SCL_MAX_KHZ;

  // Bit engine states
  typedef enum logic [2:0] {
    I2CSB_IDLE = 3'b000,
    I2CSB_ADR  = 3'b001,
    I2CSB_AAK  = 3'b011,
    I2CSB_RXB  = 3'b010,
    I2CSB_RAK  = 3'b110,
    I2CSB_TXB  = 3'b111,
    I2CSB_TAK  = 3'b101,
    I2CSB_HOLD = 3'b100
  } i2csb_state_t;

endpackage : i2csb_pkg

// File: rtl/i2csb_buf_if.sv
`timescale 1ns/1ps
// Port from a user, the engine or the firmware side, into the buffer RAM
interface i2csb_buf_if;
  logic       we;    // Write strobe
  logic [4:0] addr;  // Byte pointer
  logic [7:0] wdata; // Write byte
  logic [7:0] rdata; // Registered read byte
  modport ram (input we, input addr, input wdata, output rdata);
  modport user (output we, output addr, output wdata, input rdata);
endinterface : i2csb_buf_if

// File: rtl/i2csb_ram.sv
`timescale 1ns/1ps
// Two-port byte buffer; each port reads out of a register
module i2csb_ram #(
  parameter int DEPTH = 32
) (
  // Clock
  input wire logic   aclk,
  // Bus side port
  i2csb_buf_if.ram   bus,
  // Firmware side port
  i2csb_buf_if.ram   cpu
);
  import i2csb_pkg::*;

  logic [7:0] mem [DEPTH];  // Storage, no reset needed

  // ---------------------------------------------------------------
  // Writes; bus side wins a same-address collision
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (cpu.we) begin
      mem[cpu.addr] <= cpu.wdata;
    end
    if (bus.we) begin
      mem[bus.addr] <= bus.wdata;
    end
  end

  // Registered reads
  always_ff @(posedge aclk) begin
    bus.rdata <= mem[bus.addr];
    cpu.rdata <= mem[cpu.addr];
  end

endmodule : i2csb_ram

// File: rtl/i2csb_top.sv
`timescale 1ns/1ps
// Two-wire slave engine with AXI4-Lite registers
module i2csb_top (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Bus pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  // Pin ownership and interrupt
  output logic             pins_owned,
  output logic             irq
);
  import i2csb_pkg::*;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] scl_s_q, sda_s_q;  // Two-stage capture
  logic       scl_p_q, sda_p_q;  // Previous synced level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
    end
  end
  wire scl  = scl_s_q[1];
  wire sda  = sda_s_q[1];
  wire rise = scl & ~scl_p_q;
  wire fall = ~scl & scl_p_q;
  // Start/stop: data moves while clock high
  wire start_c = scl & scl_p_q & ~sda & sda_p_q;
  wire stop_c  = scl & scl_p_q & sda & ~sda_p_q;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic [4:0]         ctrl_q, ctrl_d;      // Mode controls
  logic [6:0]         addr_q, addr_d;      // Own address
  logic [I2CSB_NEV-1:0] stat_q, stat_d;    // Sticky events
  logic [I2CSB_NEV-1:0] mask_q, mask_d;    // Interrupt mask
  logic [7:0]         txd_q, txd_d;        // Byte to send
  logic [7:0]         rxd_q, rxd_d;        // Last received byte
  logic [I2CSB_NEV-1:0] ev;                // Event pulses

  wire en   = ctrl_q[I2CSB_CTL_EN];
  wire bufm = ctrl_q[I2CSB_CTL_BUF];
  wire mon  = ctrl_q[I2CSB_CTL_MON];

  // ---------------------------------------------------------------
  // Bit engine
  // ---------------------------------------------------------------
  i2csb_state_t st_q, st_d;
  logic [3:0] bit_q, bit_d;     // Bits left in byte
  logic [7:0] sh_q, sh_d;       // Shift register
  logic       rd_q, rd_d;       // Master reading
  logic       sda_q, sda_d;     // Data line pulled low
  logic       scl_q, scl_d;     // Clock line held low
  logic       first_q, first_d; // Next write byte is pointer
  logic [4:0] ptr_q, ptr_d;     // Buffer pointer
  i2csb_state_t ret_q, ret_d;   // State after a stall
  logic       rls;              // Firmware releases stall
  logic       ack_ok;           // Byte accepted

  i2csb_buf_if bus_p ();
  i2csb_buf_if cpu_p ();

  // Next-state logic of the engine
  always_comb begin
    st_d = st_q; bit_d = bit_q; sh_d = sh_q; rd_d = rd_q;
    sda_d = sda_q; scl_d = scl_q; first_d = first_q;
    ptr_d = ptr_q; ret_d = ret_q; rxd_d = rxd_q;
    ev = '0;
    bus_p.we = 1'b0;
    bus_p.addr = ptr_q;
    bus_p.wdata = sh_q;
    ack_ok = !ctrl_q[I2CSB_CTL_NACK];
    ev[I2CSB_ST_ACT] = mon & (fall | start_c);
    if (!en || mon) begin
      // Disabled or listening only: never drive the lines
      st_d = I2CSB_IDLE; sda_d = 1'b0; scl_d = 1'b0;
    end else if (stop_c) begin
      st_d = I2CSB_IDLE; sda_d = 1'b0; scl_d = 1'b0;
      ev[I2CSB_ST_STOP] = 1'b1;
    end else if (start_c) begin
      st_d = I2CSB_ADR; bit_d = 4'd8; sda_d = 1'b0;
      scl_d = 1'b0; first_d = 1'b1;
      ev[I2CSB_ST_START] = 1'b1;
    end else begin
      unique case (st_q)
        I2CSB_IDLE: ;
        I2CSB_ADR: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda};
            bit_d = bit_q - 4'd1;
          end
          if (fall && bit_q == 4'd0) begin
            // Hardware compare of 7-bit address
            if (sh_q[7:1] == addr_q) begin
              rd_d = sh_q[0];
              sda_d = 1'b1;
              st_d = I2CSB_AAK;
              ev[I2CSB_ST_ADDR] = 1'b1;
              if (!bufm) begin
                scl_d = 1'b1;
                ret_d = I2CSB_AAK;
                st_d = I2CSB_HOLD;
              end
            end else begin
              st_d = I2CSB_IDLE;
            end
          end
        end
        I2CSB_HOLD: begin
          // Stalled with clock low until firmware acts
          if (rls) begin
            scl_d = 1'b0;
            st_d = ret_q;
          end
        end
        I2CSB_AAK, I2CSB_RAK: begin
          if (fall) begin
            sda_d = 1'b0;
            bit_d = 4'd8;
            st_d = rd_q ? I2CSB_TXB : I2CSB_RXB;
            if (rd_q) begin
              // Buffered reads return what firmware placed
              sh_d = bufm ? bus_p.rdata : txd_q;
              sda_d = bufm ? ~bus_p.rdata[7] : ~txd_q[7];
              if (bufm) begin
                ptr_d = ptr_q + 5'd1;
              end
            end
          end
        end
        I2CSB_RXB: begin
          if (rise) begin
            sh_d = {sh_q[6:0], sda};
            bit_d = bit_q - 4'd1;
          end
          if (fall && bit_q == 4'd0) begin
            rxd_d = sh_q;
            ev[I2CSB_ST_RX] = 1'b1;
            sda_d = ack_ok;
            st_d = I2CSB_RAK;
            if (bufm) begin
              if (first_q) begin
                ptr_d = sh_q[I2CSB_PTR_W-1:0];
                first_d = 1'b0;
              end else begin
                bus_p.we = 1'b1;
                ptr_d = ptr_q + 5'd1;
              end
            end else begin
              scl_d = 1'b1;
              ret_d = I2CSB_RAK;
              st_d = I2CSB_HOLD;
            end
          end
        end
        I2CSB_TXB: begin
          if (fall) begin
            bit_d = bit_q - 4'd1;
            sh_d = {sh_q[6:0], 1'b0};
            sda_d = (bit_q == 4'd1) ? 1'b0 : ~sh_q[6];
            if (bit_q == 4'd1) begin
              st_d = I2CSB_TAK;
              ev[I2CSB_ST_TX] = 1'b1;
              if (!bufm) begin
                ret_d = I2CSB_TAK;
                st_d = I2CSB_HOLD;
              end
            end
          end
        end
        I2CSB_TAK: begin
          if (rise) begin
            if (sda) begin
              ev[I2CSB_ST_NAKD] = 1'b1;
              st_d = I2CSB_IDLE;
            end else begin
              st_d = I2CSB_RAK;
            end
          end
        end
        default: st_d = I2CSB_IDLE;
      endcase
      // Assert the stall once the clock is low
      if (st_d == I2CSB_HOLD && st_q != I2CSB_HOLD) begin
        scl_d = 1'b1;
      end
    end
  end

  // Engine registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= I2CSB_IDLE; bit_q <= 4'h0; sh_q <= 8'h00;
      rd_q <= 1'b0; sda_q <= 1'b0; scl_q <= 1'b0;
      first_q <= 1'b1; ptr_q <= 5'h00; ret_q <= I2CSB_IDLE;
      rxd_q <= 8'h00;
    end else begin
      st_q <= st_d; bit_q <= bit_d; sh_q <= sh_d;
      rd_q <= rd_d; sda_q <= sda_d; scl_q <= scl_d;
      first_q <= first_d; ptr_q <= ptr_d; ret_q <= ret_d;
      rxd_q <= rxd_d;
    end
  end

  // ---------------------------------------------------------------
  // Buffer RAM
  // ---------------------------------------------------------------
  i2csb_ram #(.DEPTH(I2CSB_BUF_DEPTH)) u_ram (
    .aclk (aclk),
    .bus  (bus_p.ram),
    .cpu  (cpu_p.ram)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  logic aw_q, w_q, bv_q, ar_q, rv_q, rw_q, wsb_q;
  logic [7:0] awa_q, ara_q;
  logic [31:0] wd_q, rd32_q;
  logic [1:0] br_q, rr_q;
  logic       awh, wh, doit, rdo;
  logic [31:0] rmux;
  logic        rerr;

  assign awh  = s_axi_awvalid & ~aw_q & ~bv_q;
  assign wh   = s_axi_wvalid & ~w_q & ~bv_q;
  assign doit = aw_q & w_q & ~bv_q & ~ar_q;
  assign rdo  = s_axi_arvalid & ~rv_q & ~ar_q;
  wire is_buf_w = awa_q[7] == 1'b1;
  assign cpu_p.we    = doit & is_buf_w & wsb_q;
  assign cpu_p.addr  = ar_q ? ara_q[6:2] : awa_q[6:2];
  assign cpu_p.wdata = wd_q[7:0];
  assign rls = doit & (awa_q == I2CSB_OFS_CTRL)
             & wd_q[I2CSB_CTL_RLS];

  // Register read mux
  always_comb begin
    rmux = 32'h0000_0000;
    rerr = 1'b0;
    if (ara_q[7]) begin
      rmux = {24'h00_0000, cpu_p.rdata};
    end else begin
      unique case (ara_q)
        I2CSB_OFS_CTRL:   rmux = {27'h0, ctrl_q};
        I2CSB_OFS_ADDR:   rmux = {25'h0, addr_q};
        I2CSB_OFS_STATUS: rmux = {25'h0, stat_q};
        I2CSB_OFS_MASK:   rmux = {25'h0, mask_q};
        I2CSB_OFS_RXDATA: rmux = {24'h0, rxd_q};
        I2CSB_OFS_TXDATA: rmux = {24'h0, txd_q};
        I2CSB_OFS_STATE:  rmux = {19'h0, ptr_q, st_q, 2'h0,
                                   sda, scl, scl_q};
        default:          rerr = 1'b1;
      endcase
    end
  end

  // Register write and status next values
  always_comb begin
    ctrl_d = ctrl_q; addr_d = addr_q; mask_d = mask_q;
    txd_d = txd_q;
    // Read of status clears; new events win over the clear
    stat_d = (rw_q && ara_q == I2CSB_OFS_STATUS) ? '0 : stat_q;
    stat_d = stat_d | ev;
    if (doit && !is_buf_w) begin
      unique case (awa_q)
        I2CSB_OFS_CTRL:   ctrl_d = {1'b0, wd_q[3:0]};
        I2CSB_OFS_ADDR:   addr_d = wd_q[6:0];
        I2CSB_OFS_MASK:   mask_d = wd_q[I2CSB_NEV-1:0];
        I2CSB_OFS_TXDATA: txd_d = wd_q[7:0];
        default: ;
      endcase
    end
  end

  // Bus handshake and register state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b0; br_q <= 2'h0;
      ar_q <= 1'b0; rv_q <= 1'b0; rr_q <= 2'h0; rw_q <= 1'b0;
      awa_q <= 8'h00; ara_q <= 8'h00; wd_q <= 32'h0;
      rd32_q <= 32'h0; wsb_q <= 1'b0;
      ctrl_q <= I2CSB_CTRL_RST; addr_q <= I2CSB_ADDR_RST;
      stat_q <= '0; mask_q <= '0; txd_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d; addr_q <= addr_d; stat_q <= stat_d;
      mask_q <= mask_d; txd_q <= txd_d;
      if (awh) begin
        aw_q <= 1'b1; awa_q <= s_axi_awaddr;
      end
      if (wh) begin
        w_q <= 1'b1; wd_q <= s_axi_wdata;
        wsb_q <= s_axi_wstrb[0];
      end
      if (doit) begin
        aw_q <= 1'b0; w_q <= 1'b0; bv_q <= 1'b1;
        br_q <= (is_buf_w || awa_q <= I2CSB_OFS_STATE)
              ? I2CSB_RESP_OK : I2CSB_RESP_ERR;
      end else if (bv_q && s_axi_bready) begin
        bv_q <= 1'b0;
      end
      // Read: address cycle, RAM cycle, then data
      rw_q <= ar_q;
      if (rdo) begin
        ar_q <= 1'b1; ara_q <= s_axi_araddr;
      end else if (ar_q) begin
        ar_q <= 1'b0;
      end
      if (rw_q) begin
        rv_q <= 1'b1; rd32_q <= rmux;
        rr_q <= rerr ? I2CSB_RESP_ERR : I2CSB_RESP_OK;
      end else if (rv_q && s_axi_rready) begin
        rv_q <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Outputs; irq and pin ownership registered, AXI readies and scl_oe combinational
  // ---------------------------------------------------------------
  logic irq_q, own_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0; own_q <= 1'b0;
    end else begin
      irq_q <= |(stat_q & mask_q);
      own_q <= en;
    end
  end
  assign s_axi_awready = awh;
  assign s_axi_wready  = wh;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = rdo;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd32_q;
  assign s_axi_rresp   = rr_q;
  assign sda_o  = 1'b0;
  assign sda_oe = sda_q;
  assign scl_o  = 1'b0;
  assign scl_oe = scl_q & ~bufm;
  assign pins_owned = own_q;
  assign irq = irq_q;

endmodule : i2csb_top

// File: test/i2csb_assertions.sv
`timescale 1ns/1ps
// Pin-level watcher for the slave; sees only top ports
module i2csb_checker (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rready,
  // Bus pins
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  // Ownership
  input wire logic        pins_owned
);
  // One domain, so one clock and one disable
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ---------------------------------------------------------------
  // Handshake steps
  // ---------------------------------------------------------------
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Answer offered but not yet taken
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence

  a_write_answer: assert property (s_wr_taken |-> ##[2:3] s_axi_bvalid)
    else $error("write response late after request");
  a_read_answer: assert property (s_rd_taken |-> ##3 s_axi_rvalid)
    else $error("read data not three cycles after address");
  a_resp_held: assert property (s_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated after handshake");
  a_awready_asked: assert property (s_axi_awready |-> s_axi_awvalid)
    else $error("write address ready without request");
  // Disabled block must leave the pins to general use
  a_pins_free: assert property (!pins_owned |-> !scl_oe && !sda_oe)
    else $error("pin driven while not owned");
  // Open drain: only ever pulls low
  a_open_drain: assert property ((scl_oe |-> !scl_o) and (sda_oe |-> !sda_o))
    else $error("pin driven high");
  // Data may move only while the clock line is low
  a_sda_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data changed while clock high");
  // A stall only extends a low clock, never cuts a high one
  a_stretch_low: assert property ($rose(scl_oe) |-> !scl_i)
    else $error("clock pulled while high");
endmodule : i2csb_checker

bind i2csb_top i2csb_checker u_chk (.*);

// File: test/i2csb_master_model.sv
`timescale 1ns/1ps
// Far-side bus master; bit period 16 system clocks
module i2csb_master_model (
  // Pacing clock
  input  wire logic aclk,
  // Resolved wire levels
  input  wire logic scl_line,
  input  wire logic sda_line,
  // Pull-downs, high holds the line low
  output logic      scl_pull,
  output logic      sda_pull
);
  int timeouts; // Clock releases that never came
  // Idle: lines left to pull-ups, clock stands still
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    timeouts = 0;
  end
  // Wait a number of system clocks
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask : wt
  // Let the clock go; the slave may hold it low a while
  task automatic rel_scl();
    int i;
    scl_pull <= 1'b0;
    for (i = 0; i < 3000; i++) begin
      wt(1);
      if (scl_line) break;
    end
    if (!scl_line) timeouts++;
    wt(3);
  endtask : rel_scl
  // One bit: data set mid low phase, sampled mid high phase
  task automatic bit_x(input logic b, output logic r);
    scl_pull <= 1'b1;
    wt(4);
    sda_pull <= ~b;
    wt(4);
    rel_scl();
    r = sda_line;
    wt(4);
  endtask : bit_x
  // Start from idle
  task automatic start();
    sda_pull <= 1'b1;
    wt(8);
  endtask : start
  // Stop (s=1) or repeated start (s=0) for the pointer protocol
  task automatic cond(input logic s);
    scl_pull <= 1'b1;
    wt(4);
    sda_pull <= s;
    wt(4);
    rel_scl();
    sda_pull <= ~s;
    wt(8);
  endtask : cond
  // Byte out, most significant first; slave answers the ninth
  task automatic byte_w(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : byte_w
  // Byte in; nak high ends the read
  task automatic byte_r(output logic [7:0] d, input logic nak);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, d[i]);
    bit_x(nak, r);
  endtask : byte_r
endmodule : i2csb_master_model

// File: test/i2c_slave_buffered_bench.sv
`timescale 1ns/1ps
module i2c_slave_buffered_bench;
  import i2csb_pkg::*;
  // Design ports, same names as the top
  logic        aclk, aresetn;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, pins_owned, irq;
  logic        m_scl, m_sda;    // Master pull-downs
  logic        ack;             // Last acknowledge seen
  logic [7:0]  d0, d1;          // Bytes read back
  int          fails, n_tests;  // Mismatches and comparisons
  int          nstr;            // Cycles the slave held the clock
  i2csb_top u_dut (.*);
  i2csb_master_model u_mst (.aclk(aclk), .scl_line(scl_i), .sda_line(sda_i),
    .scl_pull(m_scl), .sda_pull(m_sda));
  // Pull-ups: a line is low while anyone pulls it
  assign scl_i = ~(m_scl | scl_oe);
  assign sda_i = ~(m_sda | sda_oe);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Count stall cycles for the no-stretch mode
  always @(posedge aclk) begin
    if (scl_oe) nstr <= nstr + 1;
  end
  task automatic check(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  // A wait that ran out ends the run
  task automatic hang_chk(logic ok);
    if (!ok) begin
      fails++;
      summarize();
    end
  endtask : hang_chk
  // Register write; ready sampled settled, before the taking edge
  task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
    logic ad, wd, ta, tw, got;
    logic [1:0] r;
    ad = 0;
    wd = 0;
    got = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int i = 0; i < 100 && !got; i++) begin
      @(negedge aclk);
      ta = s_axi_awready & ~ad;
      tw = s_axi_wready & ~wd;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      ad |= ta;
      wd |= tw;
    end
    s_axi_bready <= 1'b0;
    hang_chk(got);
    check("bresp", r, er);
  endtask : wr
  // Register read with expected data and response
  task automatic rd(logic [7:0] a, logic [31:0] ed, logic [1:0] er);
    logic got, ta;
    logic [31:0] d;
    logic [1:0] r;
    got = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int i = 0; i < 100 && !got; i++) begin
      @(negedge aclk);
      ta = s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    hang_chk(got);
    check("rdata", d, ed);
    check("rresp", r, er);
  endtask : rd
  // Wait until the slave holds the clock low
  task automatic stall();
    for (int i = 0; i < 2000 && !scl_oe; i++) @(negedge aclk);
    hang_chk(scl_oe);
  endtask : stall
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values, unmapped place, enable takes the pins
  task automatic t_regs();
    check("owned", pins_owned, 1'b0);
    rd(I2CSB_OFS_CTRL, 32'h00, I2CSB_RESP_OK);
    rd(I2CSB_OFS_ADDR, 32'h08, I2CSB_RESP_OK);
    rd(8'h40, 32'h00, I2CSB_RESP_ERR);
    wr(8'h40, 32'hFF, I2CSB_RESP_ERR);
    wr(I2CSB_OFS_CTRL, 32'h01, I2CSB_RESP_OK);
    wr(I2CSB_OFS_MASK, 32'h7F, I2CSB_RESP_OK);
    rd(I2CSB_OFS_MASK, 32'h7F, I2CSB_RESP_OK);
    check("owned", pins_owned, 1'b1);
  endtask : t_regs
  // Default mode: stall after address and after each byte
  task automatic t_legacy();
    fork
      begin
        u_mst.start();
        u_mst.byte_w(8'h10, ack);
        check("addr ack", ack, 1'b1);
        u_mst.byte_w(8'h3C, ack);
        check("data ack", ack, 1'b1);
        u_mst.cond(1'b1);
      end
      begin
        stall();
        check("irq", irq, 1'b1);
        rd(I2CSB_OFS_STATUS, 32'h11, I2CSB_RESP_OK);
        repeat (3) @(posedge aclk);
        check("irq", irq, 1'b0);
        wr(I2CSB_OFS_CTRL, 32'h11, I2CSB_RESP_OK);
        stall();
        rd(I2CSB_OFS_RXDATA, 32'h3C, I2CSB_RESP_OK);
        wr(I2CSB_OFS_CTRL, 32'h11, I2CSB_RESP_OK);
      end
    join
    rd(I2CSB_OFS_STATUS, 32'h0A, I2CSB_RESP_OK);
  endtask : t_legacy
  // Foreign address: no acknowledge; masked events keep irq low
  task automatic t_nomatch();
    wr(I2CSB_OFS_MASK, 32'h00, I2CSB_RESP_OK);
    u_mst.start();
    u_mst.byte_w(8'h54, ack);
    check("foreign ack", ack, 1'b0);
    u_mst.cond(1'b1);
    check("irq masked", irq, 1'b0);
    rd(I2CSB_OFS_STATUS, 32'h18, I2CSB_RESP_OK);
  endtask : t_nomatch
  // Buffered mode: pointer byte, wrap at the top, read back
  task automatic t_buf();
    int n0;
    n0 = nstr;
    wr(I2CSB_OFS_CTRL, 32'h03, I2CSB_RESP_OK);
    wr(8'hA4, 32'hC3, I2CSB_RESP_OK);
    wr(8'hA8, 32'h7E, I2CSB_RESP_OK);
    u_mst.start();
    u_mst.byte_w(8'h10, ack);
    u_mst.byte_w(8'h1F, ack);
    u_mst.byte_w(8'h11, ack);
    u_mst.byte_w(8'h22, ack);
    check("buf ack", ack, 1'b1);
    u_mst.cond(1'b1);
    rd(8'hFC, 32'h11, I2CSB_RESP_OK);
    rd(8'h80, 32'h22, I2CSB_RESP_OK);
    u_mst.start();
    u_mst.byte_w(8'h10, ack);
    u_mst.byte_w(8'h09, ack);
    u_mst.cond(1'b0);
    u_mst.byte_w(8'h11, ack);
    u_mst.byte_r(d0, 1'b0);
    u_mst.byte_r(d1, 1'b1);
    u_mst.cond(1'b1);
    check("first read", d0, 8'hC3);
    check("next read", d1, 8'h7E);
    check("stall cycles", nstr - n0, 0);
    check("master waits", u_mst.timeouts, 0);
  endtask : t_buf
  // Main sequence
  initial begin
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    fails = 0;
    n_tests = 0;
    nstr = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_legacy();
    t_nomatch();
    t_buf();
    summarize();
  end
  // Hang guard
  initial begin
    repeat (90000) @(posedge aclk);
    hang_chk(1'b0);
  end
endmodule : i2c_slave_buffered_bench
